// >>> rtl/sdm_pkg.sv
package sdm_pkg;

	// clock and phase-delay timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int PHASE_DLY_NS = 3000;
	// least time, so round up to whole cycles
	localparam int PHASE_DLY_CYC = (PHASE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLY_W = 8;
	localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(PHASE_DLY_CYC - 1);
	localparam logic [DLY_W-1:0] DLY_HOLD = DLY_W'(PHASE_DLY_CYC);

	// bus widths
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;

	// target return stack depth
	localparam logic [1:0] DEPTH_MAX = 2'h2;
	localparam logic [1:0] DEPTH_RST = 2'h0;

	// opcode decode
	localparam logic [DATA_W-1:0] OP_RETURN = 8'h48;
	localparam logic [DATA_W-1:0] OP_RETURN_SKIP = 8'h49;
	localparam logic [DATA_W-1:0] OP_LONG_CALL_LO = 8'h68;
	localparam logic [DATA_W-1:0] OP_LONG_CALL_HI = 8'h6f;
	localparam logic [DATA_W-1:0] OP_PAGED_CALL_LO = 8'h80;
	localparam logic [DATA_W-1:0] OP_PAGED_CALL_HI = 8'hbe;
	localparam logic [DATA_W-1:0] OP_TABLE_LOAD = 8'hbf;

	// addresses where single-byte jumps alias the paged call
	localparam logic [ADDR_W-1:0] PAGE2_LO = 9'h080;
	localparam logic [ADDR_W-1:0] PAGE3_HI = 9'h0ff;
	localparam logic [ADDR_W-1:0] ADDR_ALIAS = 9'h07f;

	// emulator bus pins taken together
	typedef struct packed {
		logic phase;
		logic skip;
		logic [ADDR_W-1:0] ad;
	} sdm_bus_type;

	localparam int BUS_W = $bits(sdm_bus_type);

	typedef enum logic {
		SDM_RUN,
		SDM_OVF
	} sdm_state_type;

endpackage

// >>> rtl/sdm_sync.sv
module sdm_sync
	import sdm_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] out_r;
	logic [WIDTH-1:0] out_nxt;
	logic [WIDTH-1:0] agree;

	// a bit only moves once stages two and three agree
	always_comb begin
		agree = ~(s2_r ^ s3_r);
		out_nxt = (agree & s3_r) | (~agree & out_r);
	end

	// s1 feeds s2 only, to keep metastability off the logic
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			out_r <= RST_VAL;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign dout = out_r;

endmodule

// >>> rtl/sdm_monitor.sv
// Summary of operation
// - latch each fetched instruction byte, timed by the phase signal, then decode it
// - during the second cycle of a two-cycle instruction, no push, and no pop except the table load pop
// - long and paged calls push; return and return-then-skip pop
// - table lookup load pushes in its first cycle, pops in its second
// - each push counts up once, each pop counts down once
// - counter saturates at two pushes; extra pushes are ignored
// - a pop with the counter at zero underflows it: stack overflow declared
// - after underflow, counting stops and overflow indicator stays lit
// - target keeps two return addresses; monitor models that two-level depth
// - updates happen on strobe formed from phase low and its delayed copy
// - paged-call push suppressed on pages 2, 3 and address 07f
module sdm_monitor
	import sdm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic phase_in,
	input wire logic skip_in,
	input wire logic [ADDR_W-1:0] ad_bus_in,
	output logic overflow_ind,
	output logic [1:0] depth,
	output logic push_evt,
	output logic pop_evt
);

	sdm_bus_type pin_bus;
	sdm_bus_type sb;

	assign pin_bus = '{phase: phase_in, skip: skip_in, ad: ad_bus_in};

	// all emulator pins cross together through one synchroniser
	sdm_sync #(
		.WIDTH(BUS_W),
		.RST_VAL('0)
	) u_sync (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.din(pin_bus),
		.dout(sb)
	);

	logic [DLY_W-1:0] dly_cnt_r, dly_cnt_nxt;
	logic strobe;
	logic [ADDR_W-1:0] addr_r, addr_nxt;
	logic [DATA_W-1:0] instr_r, instr_nxt;
	logic skip_r, skip_nxt;
	logic blk_r, blk_nxt;
	logic dec_pend_r, dec_pend_nxt;
	logic tbl_pend_r, tbl_pend_nxt;
	logic push_r, push_nxt;
	logic pop_r, pop_nxt;
	logic [1:0] depth_r, depth_nxt;
	sdm_state_type state_r, state_nxt;
	logic is_return, is_long, is_paged_raw, is_paged, is_tbl_load;

	// delayed phase copy: strobe fires once phase has stayed low for the delay
	always_comb begin
		if (sb.phase) begin
			dly_cnt_nxt = '0;
		end else if (dly_cnt_r == DLY_HOLD) begin
			dly_cnt_nxt = dly_cnt_r;
		end else begin
			dly_cnt_nxt = dly_cnt_r + DLY_W'(1);
		end
	end

	// phase rising before the delay ends gives no strobe, like the nor gate
	assign strobe = !sb.phase && (dly_cnt_r == DLY_LAST);

	// capture address while high, instruction byte at the strobe
	always_comb begin
		addr_nxt = sb.phase ? sb.ad : addr_r;
		instr_nxt = instr_r;
		skip_nxt = skip_r;
		blk_nxt = blk_r;
		dec_pend_nxt = 1'b0;
		if (strobe) begin
			instr_nxt = sb.ad[DATA_W-1:0];
			skip_nxt = sb.skip;
			// single-byte jumps here share the paged-call code
			blk_nxt = ((addr_r >= PAGE2_LO) && (addr_r <= PAGE3_HI)) ||
				(addr_r == ADDR_ALIAS);
			dec_pend_nxt = 1'b1;
		end
	end

	// opcode classes of the latched byte
	always_comb begin
		is_return = (instr_r == OP_RETURN) || (instr_r == OP_RETURN_SKIP);
		is_long = (instr_r >= OP_LONG_CALL_LO) && (instr_r <= OP_LONG_CALL_HI);
		is_paged_raw = (instr_r >= OP_PAGED_CALL_LO) && (instr_r <= OP_PAGED_CALL_HI);
		is_paged = is_paged_raw && !blk_r;
		is_tbl_load = (instr_r == OP_TABLE_LOAD);
	end

	// decode to one-cycle push and pop strobes
	always_comb begin
		push_nxt = 1'b0;
		pop_nxt = 1'b0;
		tbl_pend_nxt = tbl_pend_r;
		if (dec_pend_r) begin
			// the table load pop lands on its second cycle even with skip high
			pop_nxt = tbl_pend_r;
			tbl_pend_nxt = 1'b0;
			if (!skip_r) begin
				push_nxt = is_long || is_paged || is_tbl_load;
				pop_nxt = tbl_pend_r || is_return;
				tbl_pend_nxt = is_tbl_load;
			end
		end
	end

	// depth counter and overflow state
	always_comb begin
		depth_nxt = depth_r;
		state_nxt = state_r;
		case (state_r)
			SDM_RUN: begin
				if (push_r && !pop_r) begin
					// deliberate overflow must not be flagged, so saturate
					if (depth_r != DEPTH_MAX) begin
						depth_nxt = depth_r + 2'h1;
					end
				end else if (pop_r && !push_r) begin
					if (depth_r == DEPTH_RST) begin
						state_nxt = SDM_OVF;
					end else begin
						depth_nxt = depth_r - 2'h1;
					end
				end
			end
			SDM_OVF: begin
				depth_nxt = depth_r;
				state_nxt = SDM_OVF;
			end
			default: begin
				state_nxt = SDM_RUN;
			end
		endcase
	end

	// reset returns to an empty stack with counting enabled
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			dly_cnt_r <= '0;
			addr_r <= '0;
			instr_r <= '0;
			skip_r <= 1'b0;
			blk_r <= 1'b0;
			dec_pend_r <= 1'b0;
			tbl_pend_r <= 1'b0;
			push_r <= 1'b0;
			pop_r <= 1'b0;
			depth_r <= DEPTH_RST;
			state_r <= SDM_RUN;
		end else begin
			dly_cnt_r <= dly_cnt_nxt;
			addr_r <= addr_nxt;
			instr_r <= instr_nxt;
			skip_r <= skip_nxt;
			blk_r <= blk_nxt;
			dec_pend_r <= dec_pend_nxt;
			tbl_pend_r <= tbl_pend_nxt;
			push_r <= push_nxt;
			pop_r <= pop_nxt;
			depth_r <= depth_nxt;
			state_r <= state_nxt;
		end
	end

	assign overflow_ind = (state_r == SDM_OVF);
	assign depth = depth_r;
	assign push_evt = push_r;
	assign pop_evt = pop_r;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence low_run;
		!sb.phase [*8];
	endsequence

	sequence tbl_fetch;
		dec_pend_r && !skip_r && is_tbl_load;
	endsequence

	a_instr_latch: assert property (strobe |=> instr_r == $past(sb.ad[DATA_W-1:0]))
		else $error("instruction byte not latched at strobe");
	a_skip_quiet: assert property (dec_pend_r && skip_r && !tbl_pend_r |=> !push_r && !pop_r)
		else $error("push or pop during second cycle");
	a_return_pops: assert property (dec_pend_r && !skip_r && is_return |=> pop_r && !push_r)
		else $error("return did not pop");
	a_call_push: assert property (dec_pend_r && !skip_r && (is_long || is_paged) |=> push_r)
		else $error("call did not push");
	// the pending pop must still stand a cycle after the push pulse
	a_tbl_seq: assert property (tbl_fetch |=> (push_r && tbl_pend_r) ##1 (tbl_pend_r || dec_pend_r))
		else $error("table load push or pending pop lost");
	a_tbl_pop: assert property (tbl_pend_r && dec_pend_r |=> pop_r)
		else $error("table load second cycle did not pop");
	a_push_count: assert property (state_r == SDM_RUN && push_r && !pop_r &&
		depth_r != DEPTH_MAX |=> depth_r == $past(depth_r) + 2'h1)
		else $error("push did not count once");
	a_push_sat: assert property (push_r && !pop_r && depth_r == DEPTH_MAX |=> depth_r == DEPTH_MAX)
		else $error("counter passed two pushes");
	a_underflow: assert property (state_r == SDM_RUN && pop_r && !push_r &&
		depth_r == DEPTH_RST |=> overflow_ind)
		else $error("underflow not flagged");
	a_ovf_hold: assert property (overflow_ind |=> overflow_ind && $stable(depth_r))
		else $error("overflow state not held");
	a_depth_bound: assert property (depth_r <= DEPTH_MAX)
		else $error("depth beyond two levels");
	a_strobe_delay: assert property (strobe |-> $past(!sb.phase, 8) && !sb.phase)
		else $error("strobe before phase delay");
	a_low_no_early: assert property ($fell(sb.phase) |-> !strobe throughout low_run)
		else $error("strobe too soon after phase fall");
	a_page_block: assert property (dec_pend_r && !skip_r && is_paged_raw && blk_r &&
		!tbl_pend_r |=> !push_r)
		else $error("paged call pushed in blocked area");

endmodule

// >>> test/sdm_emu_model.sv
module sdm_emu_model
	import sdm_pkg::*;
(
	input wire logic ref_clk,
	output logic phase_in,
	output logic skip_in,
	output logic [ADDR_W-1:0] ad_bus_in
);
	timeunit 1ns;
	timeprecision 1ns;

	// idle with address phase up so the synchroniser sees no data phase
	initial begin
		phase_in = 1'b1;
		skip_in = 1'b0;
		ad_bus_in = '0;
	end

	// one instruction cycle: address while phase high, byte while low
	task automatic fetch(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] op,
		input logic sk, input int low);
		@(posedge ref_clk);
		phase_in <= 1'b1;
		ad_bus_in <= a;
		repeat (6) @(posedge ref_clk);
		phase_in <= 1'b0;
		skip_in <= sk;
		ad_bus_in <= ADDR_W'(op);
		repeat (low) @(posedge ref_clk);
		phase_in <= 1'b1;
		skip_in <= ~sk;
		ad_bus_in <= ~ADDR_W'(op); // stale byte must not linger
	endtask
endmodule

// >>> test/subroutine_stack_depth_monitor_test.sv
module subroutine_stack_depth_monitor_test import sdm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 60000;
	logic ref_clk;
	logic arst_n;
	logic phase_in;
	logic skip_in;
	logic [ADDR_W-1:0] ad_bus_in;
	logic overflow_ind;
	logic [1:0] depth;
	logic push_evt;
	logic pop_evt;
	logic [1:0] exp_depth;
	logic exp_ovf;
	bit pend;
	int errors = 0;
	int comparisons = 0;
	int n_push;
	int n_pop;
	int cycles = 0;

	sdm_monitor dut (.ref_clk(ref_clk), .arst_n(arst_n), .phase_in(phase_in),
		.skip_in(skip_in), .ad_bus_in(ad_bus_in), .overflow_ind(overflow_ind),
		.depth(depth), .push_evt(push_evt), .pop_evt(pop_evt));
	sdm_emu_model emu (.ref_clk(ref_clk), .phase_in(phase_in), .skip_in(skip_in),
		.ad_bus_in(ad_bus_in));

	// 50 MHz clock
	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;

	// pulse counters and hang guard
	always @(posedge ref_clk) begin
		n_push += (push_evt === 1'b1);
		n_pop += (pop_evt === 1'b1);
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic check(input logic [1:0] seen, input logic [1:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic do_reset(input int n);
		arst_n <= 1'b0;
		repeat (n) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		exp_depth = 2'h0;
		exp_ovf = 1'b0;
		pend = 0;
		check(depth, exp_depth, "reset depth");
		check({1'b0, overflow_ind}, 2'h0, "reset overflow");
	endtask

	// push expected from the opcode classes and the blocked paged-call area
	function automatic bit push_op(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] op);
		return op inside {[OP_LONG_CALL_LO:OP_LONG_CALL_HI], OP_TABLE_LOAD} ||
			(op inside {[OP_PAGED_CALL_LO:OP_PAGED_CALL_HI]} &&
			!(a inside {[ADDR_ALIAS:PAGE3_HI]}));
	endfunction

	// one fetch; expectation worked out before, compared after
	task automatic step(input logic [8:0] a, input logic [7:0] op, input logic sk,
		input int low = 170);
		bit ok, pu, po, fr;
		logic [1:0] d0;
		ok = low > 160; // a short data phase yields no strobe
		pu = ok && !sk && push_op(a, op);
		po = ok && (pend || (!sk && op inside {OP_RETURN, OP_RETURN_SKIP}));
		if (ok)
			pend = !sk && op == OP_TABLE_LOAD;
		fr = exp_ovf;
		d0 = exp_depth;
		n_push = 0;
		n_pop = 0;
		emu.fetch(a, op, sk, low);
		repeat (8) @(posedge ref_clk);
		if (!fr && pu && d0 < 2'h2)
			exp_depth++;
		if (!fr && po && exp_depth == 2'h0)
			exp_ovf = 1'b1;
		else if (!fr && po)
			exp_depth--;
		check(depth, exp_depth, "depth");
		check({1'b0, overflow_ind}, {1'b0, exp_ovf}, "overflow");
		if (!fr)
			check(2'(n_pop), {1'b0, po}, "pops");
		if (!fr && !(pu && d0 == 2'h2))
			check(2'(n_push), {1'b0, pu}, "pushes");
	endtask

	// corner cases first, then a random instruction stream
	initial begin
		static logic [7:0] ops [6] = '{8'h48, 8'h49, 8'h6c, 8'ha5, 8'hbf, 8'h80};
		logic [7:0] op;
		arst_n = 1'b0;
		void'($urandom(4));
		do_reset(20);
		step(9'h010, 8'h68, 0);
		step(9'h011, 8'h55, 1);
		step(9'h020, 8'h80, 0);
		step(9'h021, 8'h6f, 0);
		step(9'h030, 8'h48, 0);
		step(9'h031, 8'h49, 0);
		step(9'h032, 8'h48, 0);
		step(9'h033, 8'h68, 0);
		step(9'h034, 8'h48, 0);
		$display("test nesting done");
		do_reset(2);
		step(9'h080, 8'hbe, 0);
		step(9'h0ff, 8'h80, 0);
		step(9'h07f, 8'h9a, 0);
		step(9'h07e, 8'hbe, 0);
		step(9'h100, 8'h80, 0);
		step(9'h040, 8'h6a, 1);
		step(9'h041, 8'h48, 1);
		$display("test paged and skip done");
		do_reset(2);
		step(9'h050, 8'hbf, 0);
		step(9'h051, 8'h33, 1);
		step(9'h052, 8'hbf, 0);
		step(9'h053, 8'h00, 0);
		step(9'h060, 8'h68, 0, 100);
		step(9'h061, 8'h68, 0);
		$display("test table and strobe done");
		for (int i = 0; i < 150; i++) begin
			op = $urandom_range(1) ? ops[$urandom_range(5)] : 8'($urandom);
			if (exp_ovf)
				do_reset(2);
			step(9'($urandom), op, pend || $urandom_range(3) == 0);
		end
		$display("test random done");
		report_and_stop();
	end
endmodule
